// File: design/sac_regs.svh
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH

// register byte addresses
`define SAC_SC1_ADDR 8'h00
`define SAC_SC2_ADDR 8'h04
`define SAC_CFG_ADDR 8'h08
`define SAC_CVH_ADDR 8'h0C
`define SAC_CVL_ADDR 8'h10
`define SAC_RESH_ADDR 8'h14
`define SAC_RESL_ADDR 8'h18

// status_control_one fields
`define SAC_SC1_DONE_BIT 7
`define SAC_SC1_IEN_BIT 6
`define SAC_SC1_CONT_BIT 5
`define SAC_SC1_RESET 8'h1F

// status_control_two fields
`define SAC_SC2_HWTRG_BIT 6
`define SAC_SC2_CFE_BIT 5
`define SAC_SC2_CGT_BIT 4
`define SAC_SC2_RESET 8'h00

// converter_config fields
`define SAC_CFG_ASYNC_BIT 0
`define SAC_CFG_LSMP_BIT 1
`define SAC_CFG_MODE10_BIT 2
`define SAC_CFG_RESET 8'h00

// channel codes
`define SAC_CH_OFF 5'h1F
`define SAC_CH_LOWREF_FIRST 5'h10
`define SAC_CH_LOWREF_LAST 5'h15

// sample lengths in conversion clock ticks, less one (sampling runs for the value plus one ticks)
`define SAC_SHORT_SAMPLE 8'h04
`define SAC_LONG_SAMPLE 8'h14

// bus responses
`define SAC_RESP_OKAY 2'h0
`define SAC_RESP_SLVERR 2'h2

`endif

// File: design/sac_pkg.sv
package sac_pkg;

    // converter sequencer states
    typedef enum logic [1:0] {
        SAC_IDLE,
        SAC_SAMPLE,
        SAC_CONVERT
    } sac_state_e;

    // status_control_one layout
    typedef struct packed {
        logic done;
        logic irq_en;
        logic cont;
        logic [4:0] channel;
    } sac_sc1_s;

    // controls toward the analog multiplexer and converter core
    typedef struct packed {
        logic power_on;
        logic sample;
        logic low_ref_sel;
        logic [4:0] channel;
        logic [9:0] dac_code;
    } sac_core_s;

endpackage : sac_pkg

// File: design/sac_top.sv
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "sac_regs.svh"

module sac_top
    import sac_pkg::*;
#(
    parameter int TICK_DIV = 2
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // system
    input wire logic hw_trigger,
    input wire logic stop_mode,
    // converter core
    input wire logic comp_above,
    output sac_core_s core,
    output logic async_clk_enable,
    output logic done_irq
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    sac_sc1_s sc1;
    logic [7:0] sc2;
    logic [7:0] cfg;
    logic [7:0] cvh;
    logic [7:0] cvl;
    logic [7:0] res_hi;
    logic [7:0] res_lo;
    logic blocked;
    sac_state_e state;
    sac_state_e next_state;
    logic [7:0] sample_cnt;
    logic [3:0] bit_idx;
    logic [9:0] sar;
    logic [7:0] div_cnt;
    logic hw_s1;
    logic hw_s2;
    logic hw_s3;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic w_lane0;

    ////////////////////////////////////////////////////////////////////////
    // axi write path: address and data taken in either order

    wire wr_fire = aw_held && w_held && !bvalid;
    wire wr_en = wr_fire && w_lane0;
    wire wr_sc1 = wr_en && (aw_addr_q == `SAC_SC1_ADDR);
    wire wr_sc2 = wr_en && (aw_addr_q == `SAC_SC2_ADDR);
    wire wr_cfg = wr_en && (aw_addr_q == `SAC_CFG_ADDR);
    wire wr_cvh = wr_en && (aw_addr_q == `SAC_CVH_ADDR);
    wire wr_cvl = wr_en && (aw_addr_q == `SAC_CVL_ADDR);
    wire wr_ro = (aw_addr_q == `SAC_RESH_ADDR) || (aw_addr_q == `SAC_RESL_ADDR);
    wire wr_mapped = wr_sc1 || wr_sc2 || wr_cfg || wr_cvh || wr_cvl || wr_ro;

    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;

    // hold address and data until both are present
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_lane0 <= 1'b0;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_held <= 1'b1;
                aw_addr_q <= awaddr;
            end
            else if (wr_fire)
            begin
                aw_held <= 1'b0;
            end
            if (wvalid && wready)
            begin
                w_held <= 1'b1;
                w_data_q <= wdata;
                w_lane0 <= wstrb[0];
            end
            else if (wr_fire)
            begin
                w_held <= 1'b0;
            end
        end
    end

    // response one cycle after both halves are held
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid <= 1'b0;
            bresp <= `SAC_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid <= 1'b1;
            // lane 0 clear on a mapped address is accepted and ignored
            bresp <= (wr_mapped || (w_lane0 == 1'b0 && aw_addr_q <= `SAC_RESL_ADDR
                && aw_addr_q[1:0] == 2'h0)) ? `SAC_RESP_OKAY : `SAC_RESP_SLVERR;
        end
        else if (bready)
        begin
            bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi read path: data registered, side effects on the taking edge

    wire rd_fire = arvalid && arready;
    wire rd_resh = rd_fire && (araddr == `SAC_RESH_ADDR);
    wire rd_resl = rd_fire && (araddr == `SAC_RESL_ADDR);
    wire rd_hit = (araddr == `SAC_SC1_ADDR) || (araddr == `SAC_SC2_ADDR)
        || (araddr == `SAC_CFG_ADDR) || (araddr == `SAC_CVH_ADDR)
        || (araddr == `SAC_CVL_ADDR) || (araddr == `SAC_RESH_ADDR)
        || (araddr == `SAC_RESL_ADDR);
    wire [7:0] rd_byte =
        (araddr == `SAC_SC1_ADDR) ? sc1 :
        (araddr == `SAC_SC2_ADDR) ? sc2 :
        (araddr == `SAC_CFG_ADDR) ? cfg :
        (araddr == `SAC_CVH_ADDR) ? cvh :
        (araddr == `SAC_CVL_ADDR) ? cvl :
        (araddr == `SAC_RESH_ADDR) ? res_hi :
        (araddr == `SAC_RESL_ADDR) ? res_lo : 8'h00;

    assign arready = !rvalid;

    // one read under way at a time
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `SAC_RESP_OKAY;
        end
        else if (rd_fire)
        begin
            rvalid <= 1'b1;
            rdata <= {24'h000000, rd_byte};
            rresp <= rd_hit ? `SAC_RESP_OKAY : `SAC_RESP_SLVERR;
        end
        else if (rready)
        begin
            rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // trigger, mode and abort decoding

    wire hw_mode = sc2[`SAC_SC2_HWTRG_BIT];
    wire cfe = sc2[`SAC_SC2_CFE_BIT];
    wire cgt = sc2[`SAC_SC2_CGT_BIT];
    wire ten_bit = cfg[`SAC_CFG_MODE10_BIT];
    wire async_sel = cfg[`SAC_CFG_ASYNC_BIT];
    wire ch_off = (sc1.channel == `SAC_CH_OFF);
    wire new_ch_off = (w_data_q[4:0] == `SAC_CH_OFF);
    wire hw_rise = hw_s2 && !hw_s3;
    wire active = (state != SAC_IDLE);
    wire wr_mode = wr_sc2 || wr_cfg || wr_cvh || wr_cvl;
    wire stop_abort = stop_mode && !async_sel;
    wire abort = wr_sc1 || wr_mode || stop_abort;
    // software start on sc1 write, hardware start on a trigger edge
    wire start_sw = wr_sc1 && !hw_mode && !new_ch_off && !stop_abort;
    wire start_hw = hw_rise && hw_mode && !ch_off && !active && !abort;

    // trigger pin synchroniser and edge history
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            hw_s1 <= 1'b0;
            hw_s2 <= 1'b0;
            hw_s3 <= 1'b0;
        end
        else
        begin
            hw_s1 <= hw_trigger;
            hw_s2 <= hw_s1;
            hw_s3 <= hw_s2;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // conversion clock enable: runs only while powered, saving idle power

    wire tick = active && (div_cnt == 8'(TICK_DIV - 1));

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !active || tick)
            div_cnt <= 8'h00;
        else
            div_cnt <= div_cnt + 8'h01;
    end

    ////////////////////////////////////////////////////////////////////////
    // completion, compare and blocking decisions

    wire sample_end = (state == SAC_SAMPLE) && tick && (sample_cnt == 8'h00);
    wire complete = (state == SAC_CONVERT) && tick && (bit_idx == 4'h0) && !abort;
    wire [9:0] final_code = {sar[9:1], comp_above};
    wire [9:0] val = ten_bit ? final_code : {2'b00, final_code[9:2]};
    wire [9:0] cmp_ref = ten_bit ? {cvh[1:0], cvl} : {2'b00, cvl};
    wire cmp_true = cgt ? (val >= cmp_ref) : (val < cmp_ref);
    wire cmp_fail = cfe && !cmp_true;
    // single conversion with failed compare ignores blocking and stops
    wire blk_hit = blocked && !(cmp_fail && !sc1.cont);
    wire transfer = complete && !cmp_fail && !blocked;
    // blocked discards rerun even in single mode
    wire restart = complete && !ch_off && (sc1.cont || blk_hit);
    wire done_clr = wr_sc1 || rd_resl;

    ////////////////////////////////////////////////////////////////////////
    // sequencer next state

    always_comb
    begin
        next_state = state;
        case (state)
            SAC_IDLE:
            begin
                if (start_sw || start_hw)
                    next_state = SAC_SAMPLE;
            end
            SAC_SAMPLE:
            begin
                if (abort)
                    next_state = start_sw ? SAC_SAMPLE : SAC_IDLE;
                else if (sample_end)
                    next_state = SAC_CONVERT;
            end
            SAC_CONVERT:
            begin
                if (abort)
                    next_state = start_sw ? SAC_SAMPLE : SAC_IDLE;
                else if (complete)
                    next_state = restart ? SAC_SAMPLE : SAC_IDLE;
            end
            default:
            begin
                next_state = SAC_IDLE;
            end
        endcase
    end

    // state, sample counter and approximation register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= SAC_IDLE;
            sample_cnt <= 8'h00;
            bit_idx <= 4'h0;
            sar <= 10'h000;
        end
        else
        begin
            state <= next_state;
            if (next_state == SAC_SAMPLE && (state != SAC_SAMPLE || abort))
                sample_cnt <= cfg[`SAC_CFG_LSMP_BIT] ? `SAC_LONG_SAMPLE
                    : `SAC_SHORT_SAMPLE;
            else if (state == SAC_SAMPLE && tick)
                sample_cnt <= sample_cnt - 8'h01;
            if (sample_end)
            begin
                bit_idx <= 4'h9;
                sar <= 10'h000;
            end
            else if (state == SAC_CONVERT && tick)
            begin
                // keep the trial bit only when the input is above it
                sar[bit_idx] <= comp_above;
                bit_idx <= bit_idx - 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // trial code, one bit per stage

    genvar gi;
    generate
        for (gi = 0; gi < 10; gi++)
        begin : g_trial
            assign core.dac_code[gi] = sar[gi] | (state == SAC_CONVERT
                && bit_idx == 4'(gi));
        end
    endgenerate

    // analog side controls
    assign core.power_on = active && !ch_off;
    assign core.sample = (state == SAC_SAMPLE);
    assign core.channel = sc1.channel;
    assign core.low_ref_sel = (sc1.channel >= `SAC_CH_LOWREF_FIRST)
        && (sc1.channel <= `SAC_CH_LOWREF_LAST);

    ////////////////////////////////////////////////////////////////////////
    // software registers

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sc1 <= `SAC_SC1_RESET;
            sc2 <= `SAC_SC2_RESET;
            cfg <= `SAC_CFG_RESET;
            cvh <= 8'h00;
            cvl <= 8'h00;
        end
        else
        begin
            if (wr_sc1)
            begin
                sc1.irq_en <= w_data_q[`SAC_SC1_IEN_BIT];
                sc1.cont <= w_data_q[`SAC_SC1_CONT_BIT];
                sc1.channel <= w_data_q[4:0];
            end
            // set wins over a clear in the same cycle
            if (transfer)
                sc1.done <= 1'b1;
            else if (done_clr)
                sc1.done <= 1'b0;
            if (wr_sc2)
                sc2 <= w_data_q[7:0];
            if (wr_cfg)
                cfg <= w_data_q[7:0];
            if (wr_cvh)
                cvh <= w_data_q[7:0];
            if (wr_cvl)
                cvl <= w_data_q[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // result registers and read blocking

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            res_hi <= 8'h00;
            res_lo <= 8'h00;
            blocked <= 1'b0;
        end
        else
        begin
            // aborts never reach here, so the last good result stays
            if (transfer)
            begin
                res_hi <= ten_bit ? {6'h00, final_code[9:8]} : 8'h00;
                res_lo <= ten_bit ? final_code[7:0] : final_code[9:2];
            end
            if (rd_resh && ten_bit)
                blocked <= 1'b1;
            else if (rd_resl)
                blocked <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // interrupt follows done with enable, one cycle later
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            done_irq <= 1'b0;
            async_clk_enable <= 1'b0;
        end
        else
        begin
            done_irq <= sc1.done && sc1.irq_en;
            async_clk_enable <= (next_state != SAC_IDLE) && async_sel;
        end
    end

endmodule : sac_top

// File: test/sac_core_model.sv
`timescale 1ns/100ps
module sac_core_model
    import sac_pkg::*;
(
    // clock
    input wire logic aclk,
    // controls from the block and the level under test
    input wire sac_core_s core,
    input wire logic [9:0] level,
    // comparator answer
    output logic comp_above
);
    logic toggle = 1'b0;
    logic [9:0] vin;
    ////////////////////////////////////////////////////////////////
    // an unpowered core floats: never show a steady answer then
    always_ff @(posedge aclk)
        toggle <= ~toggle;
    // low reference reads as zero
    assign vin = core.low_ref_sel ? 10'h000 : level;
    assign comp_above = core.power_on ? (vin >= core.dac_code) : toggle;
endmodule : sac_core_model

// File: test/sac_properties.sv
`timescale 1ns/100ps
module sac_properties
    import sac_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // converter side
    input wire sac_core_s core,
    input wire logic async_clk_enable,
    input wire logic done_irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////
    // conversion steps: power up, then sampling hands over to trials
    sequence s_start;
        !core.power_on ##1 core.power_on;
    endsequence
    sequence s_sample_end;
        core.power_on && core.sample ##1 core.power_on && !core.sample;
    endsequence
    property p_reset_idle;
        $rose(aresetn) |-> !core.power_on && !done_irq && !async_clk_enable;
    endproperty
    property p_off;
        core.channel == 5'h1F |-> !core.power_on;
    endproperty
    property p_lowref;
        core.power_on && core.channel inside {[5'h10:5'h15]} |-> core.low_ref_sel;
    endproperty
    property p_pin;
        core.power_on && core.channel < 5'h10 |-> !core.low_ref_sel;
    endproperty
    property p_sample_first;
        s_start |-> core.sample;
    endproperty
    // first trial after sampling must be the top bit alone
    property p_sar_msb;
        s_sample_end |-> core.dac_code == 10'h200;
    endproperty
    // request lags the flag by one cycle, which lags the last tick
    property p_irq_cause;
        $rose(done_irq) |-> $past(core.power_on, 2);
    endproperty
    property p_async;
        async_clk_enable |-> core.power_on;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("active after reset");
    a_off: assert property (p_off) else $error("powered on channel off");
    a_lowref: assert property (p_lowref) else $error("low reference not routed");
    a_pin: assert property (p_pin) else $error("pin channel routed to reference");
    a_sample_first: assert property (p_sample_first) else $error("no sampling");
    a_sar_msb: assert property (p_sar_msb) else $error("bad first trial");
    a_irq_cause: assert property (p_irq_cause) else $error("request w/o completion");
    a_async: assert property (p_async) else $error("async clock while idle");
endmodule : sac_properties

bind sac_top sac_properties sac_properties_inst (.aclk(aclk), .aresetn(aresetn), .core(core),
    .async_clk_enable(async_clk_enable), .done_irq(done_irq));

// File: test/tb_top.sv
`timescale 1ns/100ps
`include "sac_regs.svh"
module tb_top;
    import sac_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, hw_trigger = 1'b0, stop_mode = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, d, d2;
    logic [31:0] wdata = 32'h0, rdata, seed;
    logic [3:0] wstrb = 4'h0;
    logic [9:0] level = 10'h000, lv;
    logic awready, wready, bvalid, arready, rvalid, comp_above, async_clk_enable, done_irq, hit;
    logic [1:0] bresp, rresp, r;
    logic [4:0] ch;
    logic [4:0] corner [4] = '{5'h00, 5'h0D, 5'h10, 5'h15};
    sac_core_s core;
    int n_fail = 0, n_checks = 0, cyc = 0;

    sac_top #(.TICK_DIV(1)) sac_top_inst (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .hw_trigger(hw_trigger), .stop_mode(stop_mode), .comp_above(comp_above),
        .core(core), .async_clk_enable(async_clk_enable), .done_irq(done_irq));
    sac_core_model sac_core_model_inst (.aclk(aclk), .core(core), .level(level),
        .comp_above(comp_above));
    ////////////////////////////////////////////////////////////////
    always #20 aclk = ~aclk;
    // hang guard, far above the under two thousand cycles the run needs
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            n_fail++;
            $display("unexpected at %0t: timeout", $time);
            test_done();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    // low reference codes read zero, pins read their level
    function automatic logic [9:0] exp_code(input logic [4:0] c, input logic [9:0] v);
        return (c >= 5'h10 && c <= 5'h15) ? 10'h000 : v;
    endfunction : exp_code
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h wanted %h", $time, got, exp);
        end
    endtask : chk
    // each channel released at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= {24'h000000, v};
        wstrb <= 4'hF;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        bready <= 1'b0;
        r = bresp;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata[7:0];
        r = rresp;
    endtask : rd
    task automatic wait_irq(input int lim);
        hit = 1'b0;
        for (int i = 0; i < lim && hit !== 1'b1; i++)
        begin
            @(posedge aclk);
            hit = done_irq;
        end
    endtask : wait_irq
    task automatic res_chk(input logic [9:0] e);
        rd(`SAC_RESH_ADDR);
        d2 = d;
        rd(`SAC_RESL_ADDR);
        chk({d2[1:0], d}, e);
    endtask : res_chk
    task automatic conv(input logic [7:0] sc1, input logic [9:0] v, input int lim);
        level <= v;
        wr(`SAC_SC1_ADDR, sc1);
        wait_irq(lim);
    endtask : conv
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////
    initial
    begin
        seed = 32'h00017F76;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        // reset contents, then an unmapped word both ways
        for (int i = 0; i < 7; i++)
        begin
            rd(8'(i * 4));
            chk(d, (i == 0) ? `SAC_SC1_RESET : 8'h00);
        end
        rd(8'h1C);
        chk(r, `SAC_RESP_SLVERR);
        wr(8'h1C, 8'h55);
        chk(r, `SAC_RESP_SLVERR);
        $display("test registers finished");
        // eight-bit mode: low byte holds the top eight bits, high byte zero
        conv(8'h47, 10'h2C9, 200);
        chk(hit, 1'b1);
        res_chk(10'h2C9 >> 2);
        // ten-bit mode; corner codes first, then random codes and levels
        wr(`SAC_CFG_ADDR, 8'h04);
        for (int i = 0; i < 10; i++)
        begin
            seed = lfsr(seed);
            ch = (i < 4) ? corner[i] : (seed[8] ? 5'(seed % 14) : 5'(16 + seed % 6));
            lv = (i == 0) ? 10'h3FF : seed[25:16];
            conv({3'b010, ch}, lv, 200);
            chk(hit, 1'b1);
            chk(core.power_on, 1'b0);
            rd(`SAC_SC1_ADDR);
            chk(d, {3'b110, ch});
            res_chk(exp_code(ch, lv));
            rd(`SAC_SC1_ADDR);
            chk(d[7], 1'b0);
        end
        // reserved code still converts; its value is meaningless
        conv(8'h56, 10'h155, 200);
        chk(hit, 1'b1);
        $display("test channels finished");
        // against 0x100: greater-or-equal first, then less-than
        wr(`SAC_CVH_ADDR, 8'h01);
        wr(`SAC_CVL_ADDR, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            lv = 10'h100 - 10'(k % 2);
            wr(`SAC_SC2_ADDR, (k < 2) ? 8'h30 : 8'h20);
            conv(8'h41, lv, 200);
            chk(hit, (k < 2) == (lv >= 10'h100));
            chk(core.power_on, 1'b0);
        end
        wr(`SAC_SC2_ADDR, 8'h00);
        $display("test compare finished");
        // high byte read blocks; the discarded result reruns until low is read
        conv(8'h43, 10'h2A5, 200);
        rd(`SAC_RESH_ADDR);
        conv(8'h43, 10'h15A, 120);
        chk(hit, 1'b0);
        chk(core.power_on, 1'b1);
        rd(`SAC_RESL_ADDR);
        chk(d, 8'hA5);
        wait_irq(200);
        chk(hit, 1'b1);
        res_chk(10'h15A);
        $display("test blocking finished");
        // continuous runs back to back until the channel is switched off
        conv(8'h62, 10'h333, 200);
        chk(hit, 1'b1);
        rd(`SAC_RESL_ADDR);
        chk(d, 8'h33);
        wait_irq(200);
        chk(hit, 1'b1);
        wr(`SAC_SC1_ADDR, 8'h1F);
        wait_irq(120);
        chk(hit, 1'b0);
        chk(core.power_on, 1'b0);
        $display("test continuous finished");
        // long sample leaves time to abort by a compare write, then by stop
        wr(`SAC_CFG_ADDR, 8'h06);
        for (int k = 0; k < 2; k++)
        begin
            conv(8'h44, 10'h0F0, 6);
            if (k == 0)
                wr(`SAC_CVL_ADDR, 8'h00);
            else
            begin
                stop_mode <= 1'b1;
                @(posedge aclk);
                stop_mode <= 1'b0;
            end
            wait_irq(150);
            chk(hit, 1'b0);
            rd(`SAC_RESL_ADDR);
            chk(d, 8'h33);
        end
        $display("test abort finished");
        // hardware trigger mode: a register write alone starts nothing
        wr(`SAC_CFG_ADDR, 8'h05);
        wr(`SAC_SC2_ADDR, 8'h40);
        conv(8'h45, 10'h1C7, 120);
        chk(hit, 1'b0);
        // stop entry with the async clock selected must not abort
        hw_trigger <= 1'b1;
        repeat (6) @(posedge aclk);
        chk(async_clk_enable, 1'b1);
        stop_mode <= 1'b1;
        @(posedge aclk);
        stop_mode <= 1'b0;
        wait_irq(200);
        hw_trigger <= 1'b0;
        chk(hit, 1'b1);
        chk(async_clk_enable, 1'b0);
        res_chk(10'h1C7);
        $display("test trigger finished");
        // reset in mid-conversion returns both result bytes to zero
        hw_trigger <= 1'b1;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        hw_trigger <= 1'b0;
        for (int i = 5; i < 7; i++)
        begin
            rd(8'(i * 4));
            chk(d, 8'h00);
        end
        $display("test reset finished");
        test_done();
    end
endmodule : tb_top
